// ---- verilog/lid_pkg.sv ----
// Constants and carriers for the LCD instruction decoder.
// Assumes a single 200 MHz clock domain and a host that presents one bus cycle per strobe.
`default_nettype none
package lid_pkg;
   localparam int ADDR_W = 7;
   localparam int TEXT_DEPTH = 128;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [7:0] CHAR_RST = 8'h20;
   // Function-set field positions.
   localparam int FS_DL_BIT = 4;
   localparam int FS_N_BIT = 3;
   localparam int FS_BANK_BIT = 2;
   localparam int FS_LSHIFT_BIT = 1;
   localparam int FS_REVERSE_BIT = 0;
   // Extended function-set field positions.
   localparam int EX_FW_BIT = 2;
   localparam int EX_NW_BIT = 0;
   // Display control and shift field positions, then shift reset values.
   localparam int DC_D_BIT = 2;
   localparam int DC_C_BIT = 1;
   localparam int DC_B_BIT = 0;
   localparam int SH_DIR_BIT = 2;
   localparam logic [3:0] LINE_EN_RST = 4'h0;
   localparam logic [7:0] SHIFT_RST = 8'h00;

   typedef enum {
      LID_NOP, LID_HOME, LID_DISP, LID_SHIFT, LID_EXFS, LID_SCROLL, LID_FSET, LID_ADDR, LID_DATA
   } lid_cmd_t;

   typedef struct packed {
      logic register_select;
      logic read_write;
      logic strobe;
      logic [7:0] data;
   } lid_bus_t;

   typedef struct packed {
      logic extended_bank_select;
      logic bus_8bit;
      logic two_line;
      logic line_shift_enable;
      logic reverse_display;
      logic font_6dot;
      logic four_line;
      logic display_on;
      logic cursor_on;
      logic blink_on;
      logic [3:0] scroll_enable;
   } lid_cfg_t;

   // Power-on defaults: byte-wide interface, every other flag off.
   localparam lid_cfg_t CFG_RST = '{bus_8bit: 1'b1, default: '0};
endpackage
`default_nettype wire

// ---- verilog/lid_decoder.sv ----
// Instruction decoder for a character LCD controller with text RAM.
// Assumes the host strobes one byte per cycle on bus_i and keeps bank discipline.
`timescale 1ns/1ps
`default_nettype none
module lid_decoder #(
   parameter int DEPTH = lid_pkg::TEXT_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Host bus
   input wire lid_pkg::lid_bus_t bus_i,
   // Text RAM read port
   input wire logic [6:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   // Decoded state
   output lid_pkg::lid_cfg_t cfg_o,
   output logic [6:0] addr_o,
   output logic [7:0] shift_o,
   output logic [3:0] shift_lines_o
);
   // Text addresses are 7 bits wide, so a deeper store could never be reached.
   if (DEPTH < 1 || DEPTH > lid_pkg::TEXT_DEPTH) begin : g_depth_check
      $error("DEPTH must be 1..128");
   end

   function automatic lid_pkg::lid_cmd_t decode(input logic is_data, input logic [7:0] d,
                                                input logic bank);
      lid_pkg::lid_cmd_t c;
      c = lid_pkg::LID_NOP;
      if (is_data) c = lid_pkg::LID_DATA;
      else if (d[7]) c = lid_pkg::LID_ADDR;
      else if (d[6:5] == 2'b01) c = lid_pkg::LID_FSET;
      else if (d[6:4] == 3'b001) c = bank ? lid_pkg::LID_SCROLL : lid_pkg::LID_SHIFT;
      else if (d[6:3] == 4'b0001) c = bank ? lid_pkg::LID_EXFS : lid_pkg::LID_DISP;
      else if (d[6:1] == 6'b000001) c = lid_pkg::LID_HOME;
      return c;
   endfunction

   logic [7:0] text_mem [DEPTH];
   lid_pkg::lid_cfg_t cfg_reg, cfg_next;
   logic [6:0] addr_reg, addr_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] rd_reg;
   logic [3:0] lines_reg, lines_next;
   lid_pkg::lid_cmd_t cmd;
   logic wr;

   assign wr = bus_i.strobe && !bus_i.read_write;

   always_comb begin
      cmd = wr ? decode(bus_i.register_select, bus_i.data, cfg_reg.extended_bank_select)
               : lid_pkg::LID_NOP;
      cfg_next = cfg_reg;
      addr_next = addr_reg;
      shift_next = shift_reg;
      case (cmd)
         lid_pkg::LID_FSET: begin
            cfg_next.bus_8bit = bus_i.data[lid_pkg::FS_DL_BIT];
            cfg_next.two_line = bus_i.data[lid_pkg::FS_N_BIT];
            cfg_next.extended_bank_select = bus_i.data[lid_pkg::FS_BANK_BIT];
            if (!bus_i.data[lid_pkg::FS_BANK_BIT]) begin
               cfg_next.line_shift_enable = bus_i.data[lid_pkg::FS_LSHIFT_BIT];
               cfg_next.reverse_display = bus_i.data[lid_pkg::FS_REVERSE_BIT];
            end
         end
         lid_pkg::LID_EXFS: begin
            cfg_next.font_6dot = bus_i.data[lid_pkg::EX_FW_BIT];
            cfg_next.four_line = bus_i.data[lid_pkg::EX_NW_BIT];
         end
         lid_pkg::LID_DISP: begin
            cfg_next.display_on = bus_i.data[lid_pkg::DC_D_BIT];
            cfg_next.cursor_on = bus_i.data[lid_pkg::DC_C_BIT];
            cfg_next.blink_on = bus_i.data[lid_pkg::DC_B_BIT];
         end
         lid_pkg::LID_SCROLL: cfg_next.scroll_enable = bus_i.data[3:0];
         lid_pkg::LID_SHIFT: begin
            if (bus_i.data[lid_pkg::SH_DIR_BIT]) shift_next = shift_reg + 8'h01;
            else shift_next = shift_reg - 8'h01;
         end
         lid_pkg::LID_ADDR: addr_next = bus_i.data[6:0];
         lid_pkg::LID_DATA: addr_next = addr_reg + 7'h01;
         lid_pkg::LID_HOME: begin
            addr_next = lid_pkg::ADDR_RST;
            shift_next = lid_pkg::SHIFT_RST;
         end
         default: ;
      endcase
      lines_next = cfg_next.line_shift_enable ? cfg_next.scroll_enable : 4'hF;
   end

   // Asynchronous power-on reset puts every flag to a fixed default.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_reg <= lid_pkg::CFG_RST;
         addr_reg <= lid_pkg::ADDR_RST;
         shift_reg <= lid_pkg::SHIFT_RST;
      end else begin
         cfg_reg <= cfg_next;
         addr_reg <= addr_next;
         shift_reg <= shift_next;
      end
   end

   // Text RAM has no reset; it is written only by data cycles.
   always_ff @(posedge sys_clk_i) begin
      if (cmd == lid_pkg::LID_DATA && 32'(addr_reg) < DEPTH) begin
         text_mem[addr_reg] <= bus_i.data;
      end
      rd_reg <= (32'(rd_addr_i) < DEPTH) ? text_mem[rd_addr_i] : lid_pkg::CHAR_RST;
   end

   // Per-line shift applies only to enabled lines when line shifting is on.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) lines_reg <= lid_pkg::LINE_EN_RST;
      else lines_reg <= lines_next;
   end

   assign rd_data_o = rd_reg;
   assign cfg_o = cfg_reg;
   assign addr_o = addr_reg;
   assign shift_o = shift_reg;
   assign shift_lines_o = lines_reg;

   AST_BANK_ON: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data == 8'h3C |=> cfg_reg.extended_bank_select)
      else $error("bank not set");
   AST_BANK_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data == 8'h38
      |=> !cfg_reg.extended_bank_select && !cfg_reg.reverse_display)
      else $error("bank or reverse not cleared");
   AST_ADDR: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data[7] |=> addr_reg == $past(bus_i.data[6:0]))
      else $error("address not loaded");
   AST_DATA_INC: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && bus_i.register_select |=> addr_reg == $past(addr_reg) + 7'h01)
      else $error("address not advanced");
   AST_DISP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data == 8'h0E && !cfg_reg.extended_bank_select
      |=> cfg_reg.display_on && cfg_reg.cursor_on && !cfg_reg.blink_on)
      else $error("display control wrong");
   AST_EXFS: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data == 8'h09 && cfg_reg.extended_bank_select
      |=> cfg_reg.four_line && !cfg_reg.font_6dot)
      else $error("extended function set wrong");
   AST_LEFT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data[7:2] == 6'h06 && !cfg_reg.extended_bank_select
      |=> shift_reg == $past(shift_reg) - 8'h01)
      else $error("left shift wrong");
   AST_RIGHT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data[7:2] == 6'h07 && !cfg_reg.extended_bank_select
      |=> shift_reg == $past(shift_reg) + 8'h01)
      else $error("right shift wrong");
   AST_HOME: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wr && !bus_i.register_select && bus_i.data[7:1] == 7'h01
      |=> addr_reg == 7'h00 && shift_reg == 8'h00)
      else $error("return home wrong");

   // Single bus cycles that the checks below are built from.
   sequence seq_fset_std;
      wr && !bus_i.register_select && bus_i.data[7:5] == 3'b001
         && !bus_i.data[lid_pkg::FS_BANK_BIT];
   endsequence
   sequence seq_scroll_wr;
      wr && !bus_i.register_select && bus_i.data[7:4] == 4'h1 && cfg_reg.extended_bank_select;
   endsequence
   sequence seq_exfs_wr;
      wr && !bus_i.register_select && bus_i.data[7:3] == 5'h01 && cfg_reg.extended_bank_select;
   endsequence
   sequence seq_text_store;
      wr && bus_i.register_select && 32'(addr_reg) < DEPTH;
   endsequence
   sequence seq_bus_read;
      bus_i.strobe && bus_i.read_write;
   endsequence

   // Release of reset must show the power-on defaults before any instruction.
   AST_RESET_STATE: assert property (@(posedge sys_clk_i) $rose(rst_b_i)
      |-> cfg_reg == lid_pkg::CFG_RST && addr_reg == lid_pkg::ADDR_RST
         && shift_reg == lid_pkg::SHIFT_RST && lines_reg == lid_pkg::LINE_EN_RST)
      else $error("reset defaults wrong");
   AST_FSET_KEEP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_fset_std |=> cfg_reg.bus_8bit == $past(bus_i.data[lid_pkg::FS_DL_BIT])
         && cfg_reg.two_line == $past(bus_i.data[lid_pkg::FS_N_BIT]))
      else $error("interface bits not kept");
   AST_LINE_SHIFT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_fset_std |=> cfg_reg.line_shift_enable == $past(bus_i.data[lid_pkg::FS_LSHIFT_BIT]))
      else $error("line shift flag wrong");
   AST_REVERSE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_fset_std |=> cfg_reg.reverse_display == $past(bus_i.data[lid_pkg::FS_REVERSE_BIT]))
      else $error("reverse flag wrong");
   AST_SCROLL: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_scroll_wr |=> cfg_reg.scroll_enable == $past(bus_i.data[3:0]))
      else $error("scroll enables wrong");
   AST_BANK_KEEP: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_exfs_wr |=> cfg_reg.extended_bank_select
         && cfg_reg.font_6dot == $past(bus_i.data[lid_pkg::EX_FW_BIT]))
      else $error("extended set changed the bank");
   AST_TEXT_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_text_store |=> text_mem[$past(addr_reg)] == $past(bus_i.data))
      else $error("text byte not stored");
   // Reads and idle cycles never change the decoded configuration, address or shift.
   AST_READ_IGNORED: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      seq_bus_read |=> $stable(cfg_reg) && $stable(addr_reg) && $stable(shift_reg))
      else $error("read changed decoded state");
   AST_IDLE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !bus_i.strobe |=> $stable(cfg_reg) && $stable(addr_reg) && $stable(shift_reg))
      else $error("idle cycle changed decoded state");
endmodule
`default_nettype wire

// ---- tb/lid_host.sv ----
// Host model that writes instruction and data bytes to the decoder.
// Assumes the decoder samples the bus on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module lid_host (
   // Clock
   input wire logic sys_clk_i,
   // Bus to the decoder
   output var lid_pkg::lid_bus_t bus_o
);
   initial begin
      bus_o = '0;
   end
   // One strobed byte; the caller keeps bank order, and released data is inverted.
   task automatic put(input logic [9:0] w);
      @(negedge sys_clk_i);
      bus_o = {w[8], w[9], 1'b1, w[7:0]};
      @(negedge sys_clk_i);
      bus_o.strobe = 1'b0;
      bus_o.data = ~w[7:0];
   endtask
endmodule
`default_nettype wire

// ---- tb/test_lid_decoder.sv ----
// Self-checking bench for the instruction decoder against a behavioural model.
// Assumes the host model drives the bus at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_lid_decoder;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [6:0] rd_addr_i = 7'h00;
   lid_pkg::lid_bus_t bus;
   lid_pkg::lid_cfg_t cfg_o, e;
   logic [7:0] rd_data_o, shift_o;
   logic [6:0] addr_o;
   logic [3:0] shift_lines_o;
   int n_mismatch = 0;
   int total_checks = 0;
   int mem [128];
   int addr, shift;
   logic [31:0] seed = 32'h426F2A93;
   logic [9:0] seq [36] = '{10'h03C, 10'h009, 10'h038, 10'h00E, 10'h153, 10'h141, 10'h0A0,
      10'h14B, 10'h0C0, 10'h14C, 10'h0E0, 10'h152, 10'h03A, 10'h03C, 10'h018, 10'h03A, 10'h01B,
      10'h018, 10'h01C, 10'h002, 10'h03B, 10'h01F, 10'h003, 10'h038, 10'h03C, 10'h00D, 10'h015,
      10'h038, 10'h00B, 10'h253, 10'h0FF, 10'h155, 10'h155, 10'h000, 10'h040, 10'h014};
   lid_decoder dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rd_addr_i(rd_addr_i),
      .rd_data_o(rd_data_o), .cfg_o(cfg_o), .addr_o(addr_o), .shift_o(shift_o),
      .shift_lines_o(shift_lines_o));
   lid_host u_host (.sys_clk_i(sys_clk_i), .bus_o(bus));
   always #2.5 sys_clk_i = ~sys_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic reset_model;
      e = '0;
      e.bus_8bit = 1'b1;
      addr = 0;
      shift = 0;
   endtask
   task automatic fail(input string msg);
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
   endtask
   task automatic check;
      total_checks++;
      if (cfg_o !== e || addr_o !== 7'(addr) || shift_o !== 8'(shift) ||
          shift_lines_o !== (e.line_shift_enable ? e.scroll_enable : 4'hF)) begin
         fail("decoded state differs from model");
      end
   endtask
   task automatic send(input logic [9:0] w);
      logic [7:0] d;
      d = w[7:0];
      u_host.put(w);
      if (w[9]) begin
      end else if (w[8]) begin
         mem[addr] = d;
         addr = (addr + 1) % 128;
      end else if (d[7]) addr = d[6:0];
      else if (d[6]) begin
      end else if (d[5]) begin
         {e.bus_8bit, e.two_line, e.extended_bank_select} = d[4:2];
         if (!d[2]) {e.line_shift_enable, e.reverse_display} = d[1:0];
      end else if (d[4]) begin
         if (e.extended_bank_select) e.scroll_enable = d[3:0];
         else shift += d[2] ? 1 : -1;
      end else if (d[3]) begin
         if (e.extended_bank_select) {e.font_6dot, e.four_line} = {d[2], d[0]};
         else {e.display_on, e.cursor_on, e.blink_on} = d[2:0];
      end else if (d[1]) begin
         addr = 0;
         shift = 0;
      end
      check();
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      fail("watchdog expired");
      give_verdict();
   end
   initial begin
      foreach (mem[i]) mem[i] = -1;
      reset_model();
      repeat (16) @(posedge sys_clk_i);
      @(negedge sys_clk_i) rst_b_i = 1'b1;
      @(negedge sys_clk_i);
      check();
      foreach (seq[i]) send(seq[i]);
      $display("decode sequence done");
      repeat (150) begin
         seed = lfsr(seed);
         send({3'b001, seed[6:0]});
         send({2'b01, seed[15:8]});
         send({2'b10, seed[23:16]});
      end
      $display("random text writes done");
      @(negedge sys_clk_i) rst_b_i = 1'b0;
      @(negedge sys_clk_i) rst_b_i = 1'b1;
      reset_model();
      @(negedge sys_clk_i);
      check();
      foreach (mem[i]) begin
         if (mem[i] >= 0) begin
            @(negedge sys_clk_i) rd_addr_i = 7'(i);
            @(negedge sys_clk_i);
            total_checks++;
            if (rd_data_o !== 8'(mem[i])) fail("text read differs");
         end
      end
      $display("readback after reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
